// ===== rtl/bank_ilk.sv
// Bank configuration store and safety output interlock, AHB-Lite slave.
`timescale 1ns/100ps
`default_nettype none
module bank_ilk
  import ilk_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_CYCLES
)(
  // Clock and reset; reset also stands for supply return.
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Machine control selection and field state.
  input wire logic [3:0] bank_sel,
  input wire logic [3:0] pair_sel,
  input wire logic viol_a,
  input wire logic viol_b,
  input wire logic reset_button,
  // Safety outputs.
  output logic first_safety_output_pair,
  output logic second_safety_output_pair,
  // Active selection and settings.
  output logic [3:0] bank_a,
  output logic [3:0] bank_b,
  output logic [3:0] pair_a,
  output logic [3:0] pair_b,
  output logic [7:0] resolution_mm,
  output logic [7:0] max_vehicle_speed,
  output logic [7:0] response_ms,
  output logic start_restart_lockout
);
  ////////////////////////////////////////////////////////////////////////
  // Millisecond tick divider.
  ////////////////////////////////////////////////////////////////////////
  logic [31:0] div_reg; // Cycle counter within one millisecond.
  logic tick; // One-cycle enable every millisecond.

  // The divider is the only slow rate; everything else uses its pulse.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_reg <= 32'h0000_0000;
      tick <= 1'b0;
    end else if (div_reg == 32'(TICK_DIV - 1)) begin
      div_reg <= 32'h0000_0000;
      tick <= 1'b1;
    end else begin
      div_reg <= div_reg + 32'h0000_0001;
      tick <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus slave and registers.
  ////////////////////////////////////////////////////////////////////////
  logic [31:0] cfg_reg [0:9]; // One settings word per bank.
  logic [31:0] ctrl_reg; // Mode and off delay.
  logic [7:0] addr_reg; // Latched address of the data phase.
  logic wr_reg; // Write data phase pending.
  logic rd_reg; // Read data phase, first cycle.
  logic rd_done_reg; // Read data phase, answer cycle.
  logic [31:0] status_w; // Block state for software.
  logic [31:0] rd_mux; // Read selection.

  // A transfer is taken when selected, active and the bus is ready.
  wire take = hsel && htrans[1] && hready;
  wire in_cfg = addr_reg < (CFG_BASE + {2'b00, BANKS_SINGLE, 2'b00});
  wire [3:0] cfg_idx = addr_reg[5:2];
  wire two_fn = ctrl_reg[0];
  wire [7:0] delay_ms = ctrl_reg[DELAY_LSB +: 8];

  // Reads take one wait state so a write just before is always seen.
  assign hreadyout = !rd_reg;
  assign hresp = 1'b0;
  assign rd_mux = in_cfg ? cfg_reg[cfg_idx] :
                  (addr_reg == CTRL_ADDR) ? ctrl_reg :
                  (addr_reg == STATUS_ADDR) ? status_w : 32'h0000_0000;

  // Address phase capture and read answer.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_reg <= 8'h00;
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      rd_done_reg <= 1'b0;
      hrdata <= 32'h0000_0000;
    end else begin
      rd_done_reg <= rd_reg;
      if (rd_reg) begin
        hrdata <= rd_mux;
        rd_reg <= 1'b0;
      end else begin
        wr_reg <= take && hwrite;
        rd_reg <= take && !hwrite;
        if (take) begin
          addr_reg <= haddr[7:0];
        end
      end
    end
  end

  // Register writes in the data phase; unmapped writes are dropped.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 10; i++) begin
        cfg_reg[i] <= CFG_RESET;
      end
      ctrl_reg <= CTRL_RESET;
    end else if (wr_reg) begin
      if (in_cfg) begin
        cfg_reg[cfg_idx] <= hwdata & CFG_MASK; // R2
      end else if (addr_reg == CTRL_ADDR) begin
        ctrl_reg <= hwdata & CTRL_MASK;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bank and pair selection.
  ////////////////////////////////////////////////////////////////////////
  // In two-function mode bank b of function B uses settings word b+5.
  wire [3:0] bank_lim = two_fn ? BANKS_DUAL : BANKS_SINGLE; // R1 R5
  wire sel_bad = (bank_sel >= bank_lim) || (pair_sel >= PAIRS_PER_BANK);
  wire [3:0] idx_a = (bank_sel < BANKS_SINGLE) ? bank_sel : 4'h0;
  wire [3:0] idx_b = (bank_sel < BANKS_DUAL) ? bank_sel + BANKS_DUAL : 4'h0;
  wire [31:0] set_a = cfg_reg[idx_a]; // R2
  // Function B reads its own word, but only to check its resolution and start codes; the outputs use set_a.
  wire [31:0] set_b = cfg_reg[idx_b]; // R5
  wire [2:0] res_code = set_a[RES_LSB +: 3];
  wire [1:0] start_mode = set_a[START_LSB +: 2];
  logic mode_last_reg; // Mode seen last cycle, for changeover.

  // Resolution lookup; codes 6 and 7 are a configuration fault.
  wire [7:0] res_w = (res_code == 3'h0) ? RES_MM_0 :
                     (res_code == 3'h1) ? RES_MM_1 :
                     (res_code == 3'h2) ? RES_MM_2 :
                     (res_code == 3'h3) ? RES_MM_3 :
                     (res_code == 3'h4) ? RES_MM_4 : RES_MM_5; // R7
  wire res_bad = res_code > 3'h5;
  // A bad function B word stops the outputs too; a half-valid bank is never run.
  wire fault_b = two_fn &&
                 ((set_b[RES_LSB +: 3] > 3'h5) ||
                  (set_b[START_LSB +: 2] > START_FULL)); // R5
  wire fault = sel_bad || res_bad || fault_b || (start_mode > START_FULL);
  wire bank_change = (bank_sel != bank_a) || (two_fn != mode_last_reg);

  // Active selection and the active bank's settings.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bank_a <= 4'h0;
      bank_b <= 4'h0;
      pair_a <= 4'h0;
      pair_b <= 4'h0;
      mode_last_reg <= 1'b0;
      resolution_mm <= RES_MM_0;
      max_vehicle_speed <= 8'h00;
      response_ms <= 8'h00;
    end else begin
      bank_a <= bank_sel;
      bank_b <= bank_sel; // R6
      pair_a <= pair_sel;
      pair_b <= pair_sel; // R6
      mode_last_reg <= two_fn;
      resolution_mm <= res_w; // R7
      max_vehicle_speed <= set_a[SPEED_LSB +: 8]; // R8
      response_ms <= set_a[RESP_LSB +: 8]; // R9
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Start-up and restart interlock.
  ////////////////////////////////////////////////////////////////////////
  ilk_state_t state_reg;
  ilk_state_t state_next;
  logic press_ok;
  logic press_bad;
  logic reject_reg; // Last press was outside the window.
  wire any_viol = viol_a || (two_fn && viol_b);
  wire clear = !any_viol && !fault;

  press_check u_press (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(tick),
    .button(reset_button),
    .press_ok(press_ok),
    .press_bad(press_bad)
  );

  // Next state. A valid press only counts with a clear field.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      power_st: begin
        if (start_mode == START_AUTO) begin
          state_next = run_st; // R10
        end else begin
          state_next = lock_st; // R11 R12
        end
      end
      lock_st: begin
        if (press_ok && clear) begin
          state_next = run_st; // R13
        end
      end
      run_st: begin
        if (bank_change && !two_fn) begin
          state_next = lock_st; // R3
        end else if (any_viol && start_mode == START_FULL) begin
          state_next = lock_st; // R12
        end
      end
      default: state_next = lock_st;
    endcase
  end

  // State register; a bad press leaves the lock as it is.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= power_st;
      reject_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (press_bad) begin
        reject_reg <= 1'b1; // R14
      end else if (press_ok) begin
        reject_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Safety outputs.
  ////////////////////////////////////////////////////////////////////////
  logic first_on_reg; // First pair before output.
  logic b_on_reg; // Function B in two-function mode.
  logic delayed_on; // First pair with delayed off.

  // The first pair drops one cycle after a violation; the second follows the off delay, or in
  // two-function mode drops two cycles after a function B violation; the response value is reported only.
  wire run_ok = (state_reg == run_st) && !fault && !bank_change;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      first_on_reg <= 1'b0;
      b_on_reg <= 1'b0;
      second_safety_output_pair <= 1'b0;
    end else begin
      first_on_reg <= run_ok && !viol_a; // R9 R10 R11
      b_on_reg <= run_ok && !viol_b;
      second_safety_output_pair <= two_fn ? b_on_reg : delayed_on; // R4
    end
  end
  assign first_safety_output_pair = first_on_reg;
  assign start_restart_lockout = (state_reg != run_st);

  off_delay u_delay (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(tick),
    .delay_ms(delay_ms),
    .on_in(first_on_reg),
    .on_out(delayed_on)
  );

  // Status word for software.
  assign status_w = {19'h00000, reject_reg, pair_a, bank_a, fault,
                     second_safety_output_pair, first_on_reg, start_restart_lockout};

  ////////////////////////////////////////////////////////////////////////
  // Checks.
  ////////////////////////////////////////////////////////////////////////
  sequence s_run_viol;
    state_reg == run_st && viol_a;
  endsequence

  a_viol_off: assert property (@(posedge hclk) disable iff (!hresetn) // R9
    s_run_viol |=> !first_safety_output_pair)
    else $error("output on after violation");
  a_lock_off: assert property (@(posedge hclk) disable iff (!hresetn) // R12
    state_reg == lock_st |=> !first_safety_output_pair)
    else $error("output on while locked");
  a_bank_relock: assert property (@(posedge hclk) disable iff (!hresetn) // R3
    state_reg == run_st && bank_change && !two_fn |=> state_reg == lock_st)
    else $error("bank change did not lock");
  a_full_relock: assert property (@(posedge hclk) disable iff (!hresetn) // R12
    s_run_viol and (start_mode == START_FULL) |=> state_reg == lock_st)
    else $error("full interlock did not relock");
  a_auto_restart: assert property (@(posedge hclk) disable iff (!hresetn) // R11
    s_run_viol and (start_mode == START_ILK_AUTO) && !bank_change
    |=> state_reg == run_st)
    else $error("automatic restart lost");
  a_power_auto: assert property (@(posedge hclk) disable iff (!hresetn) // R10
    state_reg == power_st && start_mode == START_AUTO |=> state_reg == run_st)
    else $error("automatic start missing");
  a_pair_link: assert property (@(posedge hclk) disable iff (!hresetn) // R6
    pair_a == pair_b && bank_a == bank_b)
    else $error("function pairs differ");
  a_bank_limit: assert property (@(posedge hclk) disable iff (!hresetn) // R5
    two_fn && bank_sel >= BANKS_DUAL |=> !first_safety_output_pair)
    else $error("bank above five accepted");
  a_second_after: assert property (@(posedge hclk) disable iff (!hresetn) // R4
    !two_fn && $rose(second_safety_output_pair) |-> $past(delayed_on))
    else $error("second pair on early");
  a_res_apply: assert property (@(posedge hclk) disable iff (!hresetn) // R7
    res_code == 3'h5 |=> resolution_mm == RES_MM_5)
    else $error("resolution not applied");
  a_speed_apply: assert property (@(posedge hclk) disable iff (!hresetn) // R8
    ##1 max_vehicle_speed == $past(set_a[SPEED_LSB +: 8]))
    else $error("speed not applied");
  a_read_wait: assert property (@(posedge hclk) disable iff (!hresetn)
    take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_read_answer: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_done_reg |-> hreadyout && hrdata == $past(rd_mux))
    else $error("read data not presented");
  a_write_nowait: assert property (@(posedge hclk) disable iff (!hresetn)
    take && hwrite |=> hreadyout)
    else $error("write stalled the bus");
  a_cfg_write: assert property (@(posedge hclk) disable iff (!hresetn) // R2
    wr_reg && in_cfg |=> cfg_reg[$past(cfg_idx)] == $past(hwdata & CFG_MASK))
    else $error("bank word not stored");
  a_press_unlock: assert property (@(posedge hclk) disable iff (!hresetn) // R13
    state_reg == lock_st && press_ok && clear |=> state_reg == run_st)
    else $error("valid press did not unlock");
  a_press_ignored: assert property (@(posedge hclk) disable iff (!hresetn) // R14
    state_reg == lock_st && press_bad |=> state_reg == lock_st)
    else $error("bad press unlocked");
  a_fault_off: assert property (@(posedge hclk) disable iff (!hresetn) // R1
    fault |=> !first_safety_output_pair)
    else $error("output on with fault");

  // Function B violation reaches the second pair through two registers.
  sequence s_b_viol;
    two_fn && viol_b ##1 two_fn;
  endsequence

  a_second_viol: assert property (@(posedge hclk) disable iff (!hresetn) // R9
    s_b_viol |=> !second_safety_output_pair)
    else $error("second pair on after violation");
endmodule
`default_nettype wire

// ===== rtl/ilk_pkg.sv
// Constants and types shared by the bank start-up interlock block.
// Summary of operation
// R1: single-function: ten banks, ten pairs, first outputs
// R2: each bank stores its own four settings
// R3: bank change needs a manual restart; code relocks only in single-function mode
// R4: second pair switches off delayed after first; in two-function mode the code drops it with function B, without delay
// R5: two-function: five banks per function, ten pairs
// R6: pair n bank b selects A and B
// R7: one resolution per bank, six values
// R8: one maximum vehicle speed per bank
// R9: violation switches outputs off within response time
// R10: automatic mode: outputs on without any reset
// R11: start interlock, then automatic restart after clear
// R12: full interlock: reset needed after power and clear
// R13: press of 0.12 s to 4 s is valid reset
// R14: shorter or longer presses are ignored
package ilk_pkg;
  // Clock and millisecond tick.
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned TICK_PERIOD_NS = 1000000;
  localparam int unsigned TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  // Reset button window in milliseconds, one tick per millisecond.
  localparam int unsigned PRESS_MIN_MS = 120;
  localparam int unsigned PRESS_MAX_MS = 4000;
  localparam logic [11:0] PRESS_MIN_TICKS = 12'(PRESS_MIN_MS * 1000000 / TICK_PERIOD_NS);
  localparam logic [11:0] PRESS_MAX_TICKS = 12'(PRESS_MAX_MS * 1000000 / TICK_PERIOD_NS);
  // Bank and pair counts.
  localparam logic [3:0] BANKS_SINGLE = 4'hA;
  localparam logic [3:0] BANKS_DUAL = 4'h5;
  localparam logic [3:0] PAIRS_PER_BANK = 4'hA;
  // Register byte addresses.
  localparam logic [7:0] CFG_BASE = 8'h00;
  localparam logic [7:0] CTRL_ADDR = 8'h40;
  localparam logic [7:0] STATUS_ADDR = 8'h44;
  // Bank configuration word fields.
  localparam int unsigned RES_LSB = 0;
  localparam int unsigned SPEED_LSB = 4;
  localparam int unsigned START_LSB = 12;
  localparam int unsigned RESP_LSB = 16;
  localparam logic [31:0] CFG_RESET = 32'h0000_2000;
  localparam logic [31:0] CFG_MASK = 32'h00FF_3FF7;
  // Control word: bit 0 two-function mode, bits 15:8 off delay in ms.
  localparam int unsigned DELAY_LSB = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0A00;
  localparam logic [31:0] CTRL_MASK = 32'h0000_FF01;
  // Start-up behaviour codes.
  localparam logic [1:0] START_AUTO = 2'h0;
  localparam logic [1:0] START_ILK_AUTO = 2'h1;
  localparam logic [1:0] START_FULL = 2'h2;
  // Resolution codes and millimetre values.
  localparam logic [7:0] RES_MM_0 = 8'h1E;
  localparam logic [7:0] RES_MM_1 = 8'h28;
  localparam logic [7:0] RES_MM_2 = 8'h32;
  localparam logic [7:0] RES_MM_3 = 8'h3C;
  localparam logic [7:0] RES_MM_4 = 8'h46;
  localparam logic [7:0] RES_MM_5 = 8'h96;
  // Interlock states.
  typedef enum logic [1:0] {power_st, lock_st, run_st} ilk_state_t;
endpackage

// ===== rtl/press_check.sv
// Reset button press length check.
`timescale 1ns/100ps
`default_nettype none
module press_check
  import ilk_pkg::*;
(
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Millisecond tick and button.
  input wire logic tick,
  input wire logic button,
  // Results, one-cycle pulses on release.
  output logic press_ok,
  output logic press_bad
);
  logic btn_reg;
  logic [11:0] len_reg;
  logic [11:0] len_next;
  wire released = btn_reg && !button;
  // Saturating count so a stuck button never wraps into the window.
  assign len_next = (len_reg == 12'hFFF) ? len_reg : len_reg + 12'h001;
  wire in_window = (len_reg >= PRESS_MIN_TICKS) && (len_reg <= PRESS_MAX_TICKS);

  // Measure each press and judge it on release.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      btn_reg <= 1'b0;
      len_reg <= 12'h000;
      press_ok <= 1'b0;
      press_bad <= 1'b0;
    end else begin
      btn_reg <= button;
      press_ok <= released && in_window; // R13
      press_bad <= released && !in_window; // R14
      if (!button) begin
        len_reg <= 12'h000;
      end else if (tick) begin
        len_reg <= len_next;
      end
    end
  end

  a_press_window: assert property (@(posedge hclk) disable iff (!hresetn) // R13
    press_ok |-> $past(len_reg) >= PRESS_MIN_TICKS && $past(len_reg) <= PRESS_MAX_TICKS)
    else $error("accepted press outside window");
  a_press_reject: assert property (@(posedge hclk) disable iff (!hresetn) // R14
    $fell(button) && !in_window |=> !press_ok && press_bad)
    else $error("bad press not rejected");
endmodule
`default_nettype wire

// ===== rtl/off_delay.sv
// Delayed switch-off for the second safety output pair.
`timescale 1ns/100ps
`default_nettype none
module off_delay (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Millisecond tick, delay and follow input.
  input wire logic tick,
  input wire logic [7:0] delay_ms,
  input wire logic on_in,
  // Delayed output.
  output logic on_out
);
  logic [7:0] cnt_reg;
  // Switch on with the input, switch off only after the delay ran out.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      on_out <= 1'b0;
      cnt_reg <= 8'h00;
    end else if (on_in) begin
      on_out <= 1'b1;
      cnt_reg <= delay_ms;
    end else if (cnt_reg == 8'h00) begin
      on_out <= 1'b0; // R4
    end else if (tick) begin
      cnt_reg <= cnt_reg - 8'h01;
    end
  end

  a_delay_off: assert property (@(posedge hclk) disable iff (!hresetn) // R4
    !on_in && cnt_reg == 8'h00 |=> !on_out)
    else $error("second pair not off after delay");
endmodule
`default_nettype wire

// ===== dv/machine_ctrl_model.sv
// Machine control and operator reset button model for the interlock block.
`timescale 1ns/100ps
`default_nettype none
module machine_ctrl_model #(
  parameter int unsigned TICK_DIV = 4
)(
  // Clock.
  input wire logic hclk,
  // Selection, field state and button towards the block.
  output var logic [3:0] bank_sel,
  output var logic [3:0] pair_sel,
  output var logic viol_a,
  output var logic viol_b,
  output var logic reset_button
);
  ////////////////////////////////////////
  // Start idle: bank 0, pair 0, fields clear, button up.
  initial begin
    bank_sel = 4'h0;
    pair_sel = 4'h0;
    viol_a = 1'b0;
    viol_b = 1'b0;
    reset_button = 1'b0;
  end
  // Selection lines move just after an edge, as real control outputs do.
  task automatic select(input logic [3:0] b, input logic [3:0] p);
    @(posedge hclk);
    bank_sel <= b;
    pair_sel <= p;
  endtask
  // Protective field state of both functions.
  task automatic field(input logic a, input logic b);
    @(posedge hclk);
    viol_a <= a;
    viol_b <= b;
  endtask
  // Button held for whole milliseconds; the scenario picks the length.
  task automatic press(input int unsigned ms);
    @(posedge hclk);
    reset_button <= 1'b1;
    repeat (ms * TICK_DIV) @(posedge hclk);
    reset_button <= 1'b0;
    @(posedge hclk);
  endtask
endmodule
`default_nettype wire

// ===== dv/tb_bank_ilk.sv
// Self-checking bench for the bank start-up interlock block.
`timescale 1ns/100ps
`default_nettype none
module tb_bank_ilk
  import ilk_pkg::*;
;
  // Short tick keeps press windows at 480 to 16000 cycles.
  localparam int unsigned TD = 4;
  logic hclk = 1'b0;
  logic hresetn, hsel, hwrite, hreadyout, hresp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [3:0] bank_sel, pair_sel, bank_a, bank_b, pair_a, pair_b;
  logic viol_a, viol_b, reset_button, start_restart_lockout;
  logic first_safety_output_pair, second_safety_output_pair;
  logic [7:0] resolution_mm, max_vehicle_speed, response_ms;
  logic [7:0] spd [10];
  logic [7:0] rsp [10];
  int seed, num_errors, checked, i;

  // One slave, so its ready is the bus ready.
  bank_ilk #(.TICK_DIV(TD)) i_dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .bank_sel, .pair_sel,
    .viol_a, .viol_b, .reset_button, .first_safety_output_pair,
    .second_safety_output_pair, .bank_a, .bank_b, .pair_a, .pair_b,
    .resolution_mm, .max_vehicle_speed, .response_ms, .start_restart_lockout
  );
  machine_ctrl_model #(.TICK_DIV(TD)) i_ctrl (
    .hclk, .bank_sel, .pair_sel, .viol_a, .viol_b, .reset_button
  );

  // A 25 ns clock.
  always #12.5 hclk = ~hclk;

  ////////////////////////////////////////
  // Expected bank word: bank 1 automatic, bank 2 start interlock, rest full.
  function automatic logic [31:0] cfg_word(input int b);
    logic [1:0] st;
    st = (b == 1) ? START_AUTO : ((b == 2) ? START_ILK_AUTO : START_FULL);
    return {8'h00, rsp[b], 2'b00, st, spd[b], 1'b0, 3'(b % 6)};
  endfunction
  // Millimetres of a resolution code: 30 to 70 in tens, then 150.
  function automatic logic [31:0] res_mm(input int c);
    return (c < 5) ? 32'(30 + 10 * c) : 32'd150;
  endfunction
  // Count every comparison and report each mismatch at once.
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // The single place where the run ends.
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Bounded wait for ready at a rising edge; a stuck slave ends the run.
  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      check("bus ready", 32'(hreadyout), 32'h1);
      report_and_stop;
    end
  endtask
  // One single-word transfer; read data lands in d.
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    hsize <= 3'h2;
    wait_ready;
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    wait_ready;
    d = hrdata;
  endtask
  // Bounded wait until both output pairs show the wanted levels.
  task automatic outs(input string what, input logic f, input logic s, input int max);
    int n;
    n = 0;
    while ({first_safety_output_pair, second_safety_output_pair} !== {f, s} && n < max) begin
      @(posedge hclk);
      n++;
    end
    check(what, 32'({first_safety_output_pair, second_safety_output_pair}), 32'({f, s}));
    if ({first_safety_output_pair, second_safety_output_pair} !== {f, s}) begin
      report_and_stop;
    end
  endtask
  // Select, settle, then compare fault flag and the A/B pairing.
  task automatic pick(input logic [3:0] b, input logic [3:0] p, input logic flt);
    i_ctrl.select(b, p);
    repeat (4) @(posedge hclk);
    bus(1'b0, 32'(STATUS_ADDR), 32'h0);
    check("fault flag", 32'(d[3]), 32'(flt));
    check("pair pairing", 32'(pair_b), 32'(pair_a));
    check("bank pairing", 32'(bank_b), 32'(bank_a));
    if (!flt) begin
      check("pair follows", 32'(pair_a), 32'(p));
      check("status bank", 32'(d[7:4]), 32'(b));
    end
  endtask
  // Violation drops the first pair at once and the second after the delay.
  task automatic trip;
    i_ctrl.field(1'b1, 1'b0);
    outs("violation off", 1'b0, 1'b1, 3);
    repeat (30) @(posedge hclk);
    check("second held", 32'(second_safety_output_pair), 32'h1);
    outs("delayed off", 1'b0, 1'b0, 25);
    i_ctrl.field(1'b0, 1'b0);
  endtask

  ////////////////////////////////////////
  // Main sequence: reset values, bank settings, then each start-up mode.
  initial begin
    seed = 3;
    num_errors = 0;
    checked = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, 32'(CFG_BASE), 32'h0);
    check("cfg reset", d, CFG_RESET);
    bus(1'b0, 32'(CTRL_ADDR), 32'h0);
    check("ctrl reset", d, CTRL_RESET);
    bus(1'b0, 32'h0000_0080, 32'h0);
    check("unmapped read", d, 32'h0);
    check("power lockout", 32'(start_restart_lockout), 32'h1);
    // Spare bits are written as ones and must read back as zero.
    for (i = 0; i < 10; i++) begin
      spd[i] = 8'($random(seed));
      rsp[i] = 8'($random(seed));
      bus(1'b1, 32'(4 * i), cfg_word(i) | 32'hFF00_C008);
    end
    for (i = 0; i < 10; i++) begin
      bus(1'b0, 32'(4 * i), 32'h0);
      check("cfg readback", d, cfg_word(i));
      pick(4'(i), 4'($unsigned($random(seed)) % 10), 1'b0);
      check("resolution", 32'(resolution_mm), res_mm(i % 6));
      check("vehicle speed", 32'(max_vehicle_speed), 32'(spd[i]));
      check("response time", 32'(response_ms), 32'(rsp[i]));
    end
    pick(4'hA, 4'h0, 1'b1);
    pick(4'h0, 4'hA, 1'b1);
    pick(4'h0, 4'h3, 1'b0);
    // Full interlock: presses outside the window leave the lock in place.
    i_ctrl.press(100);
    repeat (10) @(posedge hclk);
    check("short press", 32'(first_safety_output_pair), 32'h0);
    bus(1'b0, 32'(STATUS_ADDR), 32'h0);
    check("press rejected", 32'(d[12]), 32'h1);
    i_ctrl.press(4200);
    repeat (10) @(posedge hclk);
    check("long press", 32'(first_safety_output_pair), 32'h0);
    i_ctrl.press(130);
    outs("valid press", 1'b1, 1'b1, 10);
    check("lockout released", 32'(start_restart_lockout), 32'h0);
    trip();
    repeat (50) @(posedge hclk);
    check("no restart", 32'(first_safety_output_pair), 32'h0);
    i_ctrl.press(3900);
    outs("late valid press", 1'b1, 1'b1, 10);
    // Banks 1 and 2 restart alone, but a bank change still wants a press.
    for (i = 1; i < 3; i++) begin
      i_ctrl.select(4'(i), 4'h2);
      outs("bank change off", 1'b0, 1'b1, 3);
      repeat (60) @(posedge hclk);
      check("bank change held", 32'(first_safety_output_pair), 32'h0);
      i_ctrl.press(200);
      outs("restart press", 1'b1, 1'b1, 10);
      trip();
      outs("auto restart", 1'b1, 1'b1, 20);
    end
    // Two-function mode: five banks a function, spare control bits drop.
    bus(1'b1, 32'(CTRL_ADDR), 32'hFFFF_0A01);
    bus(1'b0, 32'(CTRL_ADDR), 32'h0);
    check("ctrl readback", d, 32'h0000_0A01);
    pick(4'h5, 4'h0, 1'b1);
    pick(4'h4, 4'($unsigned($random(seed)) % 10), 1'b0);
    outs("two-function on", 1'b1, 1'b1, 10);
    // A function B violation drops the second pair and relocks the full bank.
    i_ctrl.field(1'b0, 1'b1);
    outs("function B off", 1'b0, 1'b0, 5);
    check("function B lock", 32'(start_restart_lockout), 32'h1);
    report_and_stop;
  end
endmodule
`default_nettype wire
